// file: rtl/crc_unit_pkg.sv
/*
  Package of the command transfer CRC unit: polynomials, widths, reset values,
  command kinds and the byte-stream carriers.
  Assumes a single 10 MHz clock domain and a command sequencer upstream.
*/
`default_nettype none
package crc_unit_pkg;
  // Identifier check polynomial x^8+x^5+x^4+1, reflected form for LSB-first shifting
  localparam logic [7:0] ID_POLY_REFL = 8'h8c;
  // Transfer check polynomial x^16+x^15+x^2+1, reflected form
  localparam logic [15:0] XFER_POLY_REFL = 16'ha001;
  // Cleared generator contents
  localparam logic [7:0] ID_CRC_CLEAR = 8'h00;
  localparam logic [15:0] XFER_CRC_CLEAR = 16'h0000;
  // Byte that stands in for concealed scratchpad data
  localparam logic [7:0] CONCEAL_FILL = 8'hff;
  // Last scratchpad offset
  localparam logic [4:0] PAD_LAST_OFFSET = 5'h1f;
  // Bits per byte and last bit counter value
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Leading identifier bytes covered by the identifier check
  localparam logic [2:0] ID_BODY_BYTES = 3'h7;

  // Command kinds; all but CMD_NONE use the transfer check
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_PAD_WRITE = 3'h1,
    CMD_PAD_READ = 3'h2,
    CMD_AUTH_READ = 3'h3,
    CMD_HASH = 3'h4
  } cmd_kind_type;

  // Byte handed over by the sequencer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic is_pad_data;
    logic [4:0] pad_offset;
  } byte_in_type;

  // Result delivered to the link logic
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_out_type;
endpackage
`default_nettype wire

// file: rtl/crc_serial_engine.sv
/*
  Bit-serial reflected CRC engine: shifts one byte LSB first, one bit per clock.
  Assumes the caller holds start for one cycle and waits for done.
*/
`default_nettype none
module crc_serial_engine
  import crc_unit_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] POLY = 16'ha001
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic start,
  input wire logic [7:0] byte_in,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] crc
);
  logic [WIDTH-1:0] crc_reg, crc_next; // Generator contents
  logic [7:0] sh_reg, sh_next; // Byte being shifted out
  logic [2:0] cnt_reg, cnt_next; // Bit position
  logic busy_reg, busy_next; // Shifting in progress
  logic done_reg, done_next; // Byte finished pulse

  // Next state of the shifter
  always_comb begin
    crc_next = crc_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (clear) begin
      // Clear wins, any byte in flight is dropped
      crc_next = '0;
      busy_next = 1'b0;
    end else if (busy_reg) begin
      // One bit, least significant first
      if (crc_reg[0] ^ sh_reg[0]) begin
        crc_next = (crc_reg >> 1) ^ POLY;
      end else begin
        crc_next = crc_reg >> 1;
      end
      sh_next = sh_reg >> 1;
      cnt_next = cnt_reg + 3'h1;
      if (cnt_reg == BIT_LAST) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end else if (start) begin
      sh_next = byte_in;
      cnt_next = 3'h0;
      busy_next = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= '0;
      sh_reg <= 8'h00;
      cnt_reg <= 3'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      crc_reg <= crc_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign crc = crc_reg;
endmodule // crc_serial_engine
`default_nettype wire

// file: rtl/command_transfer_crc_unit.sv
/*
  Command transfer CRC unit: identifier check byte and transfer check word,
  fed byte by byte by the command sequencer and delivered as bytes to the link.
  Assumes the sequencer is on the same clock and waits on byte_ready.
*/
// Contract
// - Identifier check is CRC8 x^8+x^5+x^4+1
// - Identifier check byte sent unmodified
// - Transfer check is CRC16 x^16+x^15+x^2+1
// - CRC16 for page, hash, pad read/write
// - Transmitted CRC16 is always complemented
// - Pad write feeds command, address, data bytes
// - Pad write CRC only when offset 11111b reached
// - Pad write may start at any offset
// - Concealed writes feed CRC, not stored
// - Pad read feeds command, address, status, data
// - Pad read CRC only at last byte
// - Concealed read feeds FFh into CRC
// - Page read feeds command, address, data, counters
// - Counters fed lowest-order byte first
// - Hash feeds command, address, control byte
`default_nettype none
module command_transfer_crc_unit
  import crc_unit_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_start,
  input wire cmd_kind_type cmd_kind,
  input wire logic conceal_flag,
  input wire byte_in_type byte_in,
  input wire logic id_start,
  input wire logic crc_request,
  input wire logic [55:0] id_body,
  output logic byte_ready,
  output logic pad_store,
  output logic [7:0] id_check,
  output logic id_check_valid,
  output var byte_out_type crc_out,
  output logic crc_withheld
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FEED = 2'b01,
    ST_SEND_LO = 2'b11,
    ST_SEND_HI = 2'b10
  } state_type;

  state_type state_reg, state_next; // Transfer sequencer state
  logic reached_end_reg, reached_end_next; // Last pad offset seen
  logic pad_store_reg, pad_store_next; // Store strobe to scratchpad
  logic withheld_reg, withheld_next; // CRC refused pulse
  logic ready_reg, ready_next; // Byte acceptance, registered for a clean output
  byte_out_type out_reg, out_next; // Result byte to link
  logic [2:0] id_idx_reg, id_idx_next; // Identifier byte index
  logic id_run_reg, id_run_next; // Identifier check running
  logic id_valid_reg, id_valid_next; // Identifier check ready
  logic [7:0] id_chk_reg, id_chk_next; // Identifier check byte
  logic x_busy, x_done, i_busy, i_done;
  logic [15:0] x_crc;
  logic [7:0] i_crc;
  logic [7:0] x_byte; // Byte fed to transfer generator
  logic x_start, i_start;

  // Whether a CRC may go out now
  function automatic logic crc_allowed(input cmd_kind_type k, input logic reached);
    if (k == CMD_PAD_WRITE || k == CMD_PAD_READ) begin
      crc_allowed = reached;
    end else begin
      crc_allowed = (k != CMD_NONE);
    end
  endfunction

  // Feed selection for transfer bytes
  always_comb begin
    x_byte = byte_in.data;
    if (cmd_kind == CMD_PAD_READ && byte_in.is_pad_data && conceal_flag) begin
      x_byte = CONCEAL_FILL;
    end
  end
  // Ready implies FEED and an idle engine, so it alone gates the take
  assign x_start = ready_reg && byte_in.valid;

  // Transfer generator, cleared at command start
  crc_serial_engine #(.WIDTH(16), .POLY(XFER_POLY_REFL)) u_xfer (
    .clock(clock), .rst_n(rst_n), .clear(cmd_start), .start(x_start),
    .byte_in(x_byte), .busy(x_busy), .done(x_done), .crc(x_crc)
  );

  // Identifier generator over seven leading bytes
  assign i_start = id_run_reg && !i_busy && !i_done && (id_idx_reg != ID_BODY_BYTES);
  crc_serial_engine #(.WIDTH(8), .POLY(ID_POLY_REFL)) u_id (
    .clock(clock), .rst_n(rst_n), .clear(id_start), .start(i_start),
    .byte_in(id_body[id_idx_reg*8 +: 8]), .busy(i_busy), .done(i_done), .crc(i_crc)
  );

  // Transfer sequencing next state
  always_comb begin
    state_next = state_reg;
    reached_end_next = reached_end_reg;
    pad_store_next = 1'b0;
    withheld_next = 1'b0;
    out_next = '0;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_start) begin
          state_next = ST_FEED;
          reached_end_next = 1'b0;
        end
      end
      ST_FEED: begin
        if (cmd_start) begin
          reached_end_next = 1'b0;
        end else if (x_start) begin
          // A byte taken blocks any request in the same cycle
          if (byte_in.is_pad_data) begin
            // Any start offset accepted; end offset tracked
            if (byte_in.pad_offset == PAD_LAST_OFFSET) begin
              reached_end_next = 1'b1;
            end
            pad_store_next = (cmd_kind == CMD_PAD_WRITE) && !conceal_flag;
          end
        end else if (crc_request && !x_busy) begin
          if (crc_allowed(cmd_kind, reached_end_reg)) begin
            state_next = ST_SEND_LO;
          end else begin
            withheld_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      ST_SEND_LO: begin
        out_next.valid = 1'b1;
        out_next.data = ~x_crc[7:0];
        state_next = ST_SEND_HI;
      end
      ST_SEND_HI: begin
        out_next.valid = 1'b1;
        out_next.data = ~x_crc[15:8];
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    // Ready one cycle after the engine goes idle, never while a byte starts
    ready_next = (state_next == ST_FEED) && !x_busy && !x_start;
  end

  // Identifier sequencing next state
  always_comb begin
    id_idx_next = id_idx_reg;
    id_run_next = id_run_reg;
    id_valid_next = id_valid_reg;
    id_chk_next = id_chk_reg;
    if (id_start) begin
      id_idx_next = 3'h0;
      id_run_next = 1'b1;
      id_valid_next = 1'b0;
    end else if (i_done) begin
      id_idx_next = id_idx_reg + 3'h1;
      if (id_idx_reg + 3'h1 == ID_BODY_BYTES) begin
        id_run_next = 1'b0;
        id_valid_next = 1'b1;
        id_chk_next = i_crc;
      end
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      reached_end_reg <= 1'b0;
      pad_store_reg <= 1'b0;
      withheld_reg <= 1'b0;
      ready_reg <= 1'b0;
      out_reg <= '0;
      id_idx_reg <= 3'h0;
      id_run_reg <= 1'b0;
      id_valid_reg <= 1'b0;
      id_chk_reg <= ID_CRC_CLEAR;
    end else begin
      state_reg <= state_next;
      reached_end_reg <= reached_end_next;
      pad_store_reg <= pad_store_next;
      withheld_reg <= withheld_next;
      ready_reg <= ready_next;
      out_reg <= out_next;
      id_idx_reg <= id_idx_next;
      id_run_reg <= id_run_next;
      id_valid_reg <= id_valid_next;
      id_chk_reg <= id_chk_next;
    end
  end

  assign byte_ready = ready_reg;
  assign pad_store = pad_store_reg;
  assign crc_withheld = withheld_reg;
  assign crc_out = out_reg;
  assign id_check = id_chk_reg;
  assign id_check_valid = id_valid_reg;

  // Checks
  property p_low_first;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == ST_SEND_LO) |=> crc_out.valid && crc_out.data == ~$past(x_crc[7:0]);
  endproperty
  a_low_first: assert property (p_low_first) else $error("low CRC byte wrong");
  property p_high_next;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == ST_SEND_HI) |=> crc_out.valid && crc_out.data == ~$past(x_crc[15:8]);
  endproperty
  a_high_next: assert property (p_high_next) else $error("high CRC byte wrong");
  property p_no_store_concealed;
    @(posedge clock) disable iff (!rst_n)
      (x_start && conceal_flag) |=> !pad_store;
  endproperty
  a_no_store_concealed: assert property (p_no_store_concealed) else $error("concealed byte stored");
  property p_withheld;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == ST_FEED && !cmd_start && !x_start && crc_request && !x_busy
       && (cmd_kind == CMD_PAD_WRITE || cmd_kind == CMD_PAD_READ) && !reached_end_reg) |=> crc_withheld ##1 !crc_out.valid;
  endproperty
  a_withheld: assert property (p_withheld) else $error("CRC sent without end offset");
  property p_clear;
    @(posedge clock) disable iff (!rst_n) cmd_start |=> x_crc == XFER_CRC_CLEAR;
  endproperty
  a_clear: assert property (p_clear) else $error("generator not cleared");
  property p_fill;
    @(posedge clock) disable iff (!rst_n)
      (x_start && !cmd_start && cmd_kind == CMD_PAD_READ && conceal_flag && byte_in.is_pad_data)
      |=> u_xfer.sh_reg == CONCEAL_FILL;
  endproperty
  a_fill: assert property (p_fill) else $error("concealed read not filled");
  sequence s_byte_shift;
    x_start ##1 x_busy [*8] ##1 x_done;
  endsequence
  property p_serial;
    @(posedge clock) disable iff (!rst_n) (x_start && !cmd_start) |-> s_byte_shift;
  endproperty
  a_serial: assert property (p_serial) else $error("byte not shifted in 8 cycles");
  property p_id_done;
    @(posedge clock) disable iff (!rst_n) id_start |=> !id_check_valid [*8];
  endproperty
  a_id_done: assert property (p_id_done) else $error("identifier check early");
endmodule // command_transfer_crc_unit
`default_nettype wire

// file: verification/link_master_model.sv
/*
  Bus master model: gathers the sent check word and rechecks the identifier.
  Assumes the unit's clock, reset and package.
*/
`default_nettype none
module link_master_model
  import crc_unit_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire byte_out_type crc_out,
  input wire logic [55:0] id_body,
  input wire logic [7:0] id_check,
  output logic [15:0] rx_word,
  output logic id_ok
);
  logic hi_reg; // Next byte is the high half
  logic [7:0] calc; // Recomputed identifier check

  // Identifier check over the leading 56 bits, LSB first
  always_comb begin
    calc = 8'h00;
    for (int i = 0; i < 56; i++) begin
      calc = (calc[0] ^ id_body[i]) ? ((calc >> 1) ^ ID_POLY_REFL) : (calc >> 1);
    end
    id_ok = (calc == id_check);
  end

  // Check word arrives low byte first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hi_reg <= 1'b0;
      rx_word <= 16'h0000;
    end else if (crc_out.valid) begin
      hi_reg <= ~hi_reg;
      if (hi_reg) begin
        rx_word[15:8] <= crc_out.data;
      end else begin
        rx_word[7:0] <= crc_out.data;
      end
    end
  end
endmodule // link_master_model
`default_nettype wire

// file: verification/command_transfer_crc_unit_tb.sv
/*
  Testbench of the command transfer CRC unit against a reference model.
  Assumes the link master model and the unit's package.
*/
`default_nettype none
module command_transfer_crc_unit_tb;
  import crc_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, cmd_start, conceal_flag, id_start, crc_request;
  cmd_kind_type cmd_kind;
  byte_in_type byte_in;
  logic [55:0] id_body;
  logic byte_ready, pad_store, id_check_valid, crc_withheld, id_ok;
  logic [7:0] id_check;
  logic [15:0] rx_word;
  byte_out_type crc_out;
  int n_errors, check_count, cycles;
  int model_crc; // Reference transfer generator

  command_transfer_crc_unit dut_u (.clock(clock), .rst_n(rst_n), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
    .conceal_flag(conceal_flag), .byte_in(byte_in), .id_start(id_start), .crc_request(crc_request),
    .id_body(id_body), .byte_ready(byte_ready), .pad_store(pad_store), .id_check(id_check),
    .id_check_valid(id_check_valid), .crc_out(crc_out), .crc_withheld(crc_withheld));
  link_master_model master_u (.clock(clock), .rst_n(rst_n), .crc_out(crc_out), .id_body(id_body),
    .id_check(id_check), .rx_word(rx_word), .id_ok(id_ok));

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One byte into the reference generator, LSB first
  function automatic int crc16(input int c, input int b);
    for (int i = 0; i < 8; i++) begin
      c = ((c ^ (b >> i)) & 1) ? ((c >> 1) ^ int'(XFER_POLY_REFL)) : (c >> 1);
    end
    return c;
  endfunction

  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // Wait for the unit to accept a byte or a request
  task automatic wait_ready();
    int n;
    n = 0;
    while (byte_ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check(16'(byte_ready), 16'h0001, "byte ready");
  endtask

  // Hand one byte over and watch the store strobe
  task automatic put(input logic [7:0] d, input logic pad, input logic [4:0] off, input logic exp_store);
    logic seen;
    wait_ready();
    byte_in = '{1'b1, d, pad, off};
    @(negedge clock);
    byte_in.valid = 1'b0;
    seen = pad_store;
    @(negedge clock);
    seen = seen | pad_store;
    check(16'(seen), 16'(exp_store), "pad store");
  endtask

  // One whole command: header, pad bytes, counters, then the check word
  task automatic run_cmd(input cmd_kind_type k, input logic hid, input int hdr, input int first, input int last,
    input bit ctr);
    logic [7:0] d, lo, hi;
    logic [31:0] cnt;
    logic wh;
    bit send;
    int n;
    send = (k == CMD_AUTH_READ || k == CMD_HASH || last == 31);
    conceal_flag = hid;
    cmd_kind = k;
    cmd_start = 1'b1;
    @(negedge clock);
    cmd_start = 1'b0;
    model_crc = 0;
    for (int i = 0; i < hdr; i++) begin
      d = 8'($urandom);
      put(d, 1'b0, 5'h00, 1'b0);
      model_crc = crc16(model_crc, d);
    end
    for (int o = first; o <= last; o++) begin
      d = 8'($urandom);
      put(d, k != CMD_AUTH_READ, 5'(o), k == CMD_PAD_WRITE && !hid);
      model_crc = crc16(model_crc, (k == CMD_PAD_READ && hid) ? 8'hff : d);
    end
    for (int c = 0; c < 2 && ctr; c++) begin
      cnt = $urandom;
      for (int b = 0; b < 4; b++) begin
        put(cnt[8*b +: 8], 1'b0, 5'h00, 1'b0);
        model_crc = crc16(model_crc, cnt[8*b +: 8]);
      end
    end
    wait_ready();
    crc_request = 1'b1;
    @(negedge clock);
    crc_request = 1'b0;
    lo = 8'h00;
    hi = 8'h00;
    wh = 1'b0;
    n = 0;
    repeat (5) begin
      if (crc_out.valid === 1'b1) begin
        if (n == 0) lo = crc_out.data;
        else hi = crc_out.data;
        n++;
      end
      wh = wh | crc_withheld;
      @(negedge clock);
    end
    check(16'(n), send ? 16'h0002 : 16'h0000, "crc bytes");
    check(16'(wh), send ? 16'h0000 : 16'h0001, "withheld");
    if (send) begin
      check({hi, lo}, 16'(~model_crc), "crc word");
      check(rx_word, 16'(~model_crc), "master word");
    end
  endtask

  // Identifier check over a random body
  task automatic id_run();
    int c, n;
    id_body = {24'($urandom), $urandom};
    id_start = 1'b1;
    @(negedge clock);
    id_start = 1'b0;
    n = 0;
    while (id_check_valid !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check(16'(id_check_valid), 16'h0001, "id valid");
    c = 0;
    for (int i = 0; i < 56; i++) begin
      c = ((c ^ int'(id_body[i])) & 1) ? ((c >> 1) ^ int'(ID_POLY_REFL)) : (c >> 1);
    end
    check(16'(id_check), 16'(c), "id check");
    check(16'(id_ok), 16'h0001, "master id");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    cmd_start = 1'b0;
    cmd_kind = CMD_NONE;
    conceal_flag = 1'b0;
    byte_in = '0;
    id_start = 1'b0;
    crc_request = 1'b0;
    id_body = '0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    void'($urandom(28328));
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    repeat (3) id_run();
    run_cmd(CMD_PAD_WRITE, 1'b0, 3, int'($urandom_range(31)), 31, 1'b0);
    run_cmd(CMD_PAD_WRITE, 1'b0, 3, 4, 30, 1'b0);
    run_cmd(CMD_PAD_WRITE, 1'b1, 3, 28, 31, 1'b0);
    run_cmd(CMD_PAD_READ, 1'b0, 4, 20, 31, 1'b0);
    run_cmd(CMD_PAD_READ, 1'b1, 4, 0, 31, 1'b0);
    run_cmd(CMD_PAD_READ, 1'b0, 4, 10, 25, 1'b0);
    run_cmd(CMD_AUTH_READ, 1'b0, 35, 1, 0, 1'b1);
    run_cmd(CMD_HASH, 1'b1, 4, 1, 0, 1'b0);
    run_cmd(CMD_NONE, 1'b0, 2, 1, 0, 1'b0);
    conclude();
  end
endmodule // command_transfer_crc_unit_tb
`default_nettype wire
